// ### dv/ddcrb_bank_assertions.sv
// Port-level concurrent checks of the converter control bank
`timescale 1ns/100ps
module ddcrb_bank_assertions
  import ddcrb_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        link_clk,
  input wire logic        link_rd,
  input wire logic        link_rd_valid,
  input wire logic        link_bit_order,
  input wire logic        link_long_address,
  input wire logic        link_soft_reset,
  input wire ddcrb_ctrl_t ctrl
);
  // --------------------------------------------------------------------------
  // Core clock domain
  // --------------------------------------------------------------------------
  property p_reset_defaults;
    @(posedge clk) disable iff (!rst_n) $rose(rst_n) |-> ctrl.i_leads_pair && ctrl.i_on_rising_edge
      && ctrl.pad_in_en && !ctrl.pad_out_en && !ctrl.twos_complement && !ctrl.soft_reset;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults) else $error("ctrl not at defaults after reset");
  // Checked from the second cycle on; ctrl is loaded on the same clk edge as the register
  property p_soft_defaults;
    @(posedge clk) disable iff (!rst_n) ctrl.soft_reset && $past(ctrl.soft_reset) |-> !ctrl.power_down_all
      && !ctrl.regulator_disable && !ctrl.twos_complement && ctrl.i_leads_pair && ctrl.pad_in_en;
  endproperty
  a_soft_defaults: assert property (p_soft_defaults) else $error("ctrl not held at defaults in soft reset");
  property p_double_drive;
    @(posedge clk) disable iff (!rst_n) ctrl.pad_out_double |-> ctrl.pad_out_en;
  endproperty
  a_double_drive: assert property (p_double_drive) else $error("double driver without output enable");
  // --------------------------------------------------------------------------
  // Link clock domain, then covers on both clocks
  // --------------------------------------------------------------------------
  property p_link_defaults;
    @(posedge link_clk) disable iff (!rst_n) $rose(rst_n) |-> !link_soft_reset && !link_bit_order
      && !link_long_address;
  endproperty
  a_link_defaults: assert property (p_link_defaults) else $error("link copies not clear after reset");
  property p_link_soft;
    @(posedge link_clk) disable iff (!rst_n) $rose(link_soft_reset) |-> ctrl.soft_reset;
  endproperty
  a_link_soft: assert property (p_link_soft) else $error("link soft reset without core bit");
  property p_link_order;
    @(posedge link_clk) disable iff (!rst_n) $changed(link_bit_order) |-> link_bit_order == ctrl.bit_order_select;
  endproperty
  a_link_order: assert property (p_link_order) else $error("link bit order differs from register");
  property p_link_long;
    @(posedge link_clk) disable iff (!rst_n)
      $changed(link_long_address) |-> link_long_address == ctrl.long_address_mode;
  endproperty
  a_link_long: assert property (p_link_long) else $error("link address length differs from register");
  property p_rd_answer;
    @(posedge link_clk) disable iff (!rst_n) link_rd |-> ##[2:20] link_rd_valid;
  endproperty
  a_rd_answer: assert property (p_rd_answer) else $error("read request not answered");
  property p_rd_pulse;
    @(posedge link_clk) disable iff (!rst_n) link_rd_valid |=> !link_rd_valid;
  endproperty
  a_rd_pulse: assert property (p_rd_pulse) else $error("read valid longer than one cycle");
  c_soft: cover property (@(posedge clk) disable iff (!rst_n) $rose(ctrl.soft_reset));
  c_rd: cover property (@(posedge link_clk) disable iff (!rst_n) link_rd_valid);
  c_dbl: cover property (@(posedge clk) disable iff (!rst_n) ctrl.pad_out_double && !ctrl.pad_in_en);
endmodule

bind ddcrb_bank ddcrb_bank_assertions i_ddcrb_bank_assertions (
  .clk(clk), .rst_n(rst_n), .link_clk(link_clk), .link_rd(link_rd), .link_rd_valid(link_rd_valid),
  .link_bit_order(link_bit_order), .link_long_address(link_long_address),
  .link_soft_reset(link_soft_reset), .ctrl(ctrl));

// ### dv/ddcrb_host_model.sv
// Behavioural serial framer on the byte side of the control bank
`timescale 1ns/100ps
module ddcrb_host_model (
  output logic            link_clk,
  output logic            link_wr,
  output logic      [4:0] link_wr_addr,
  output logic      [7:0] link_wr_data,
  output logic            link_rd,
  output logic      [4:0] link_rd_addr,
  input  wire logic [7:0] link_rd_data,
  input  wire logic       link_rd_valid
);
  logic run = 1'b1;
  // Serial clock stands low between frames, as a real framer's would
  initial begin
    link_clk = 1'b0;
    link_wr = 1'b0;
    link_rd = 1'b0;
    link_wr_addr = 5'h00;
    link_wr_data = 8'h00;
    link_rd_addr = 5'h00;
    #3;
    forever #6 link_clk = run ? ~link_clk : 1'b0;
  end
  // Single-byte frames only, so a bit-order change never splits a frame
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    run = 1'b1;
    repeat (3) @(posedge link_clk);
    // Falling edge drive keeps half a cycle clear of the sampling edge
    @(negedge link_clk);
    link_wr      = 1'b1;
    link_wr_addr = a;
    link_wr_data = d;
    @(negedge link_clk);
    link_wr      = 1'b0;
    link_wr_addr = ~a;
    link_wr_data = ~d;
    repeat (20) @(posedge link_clk);
    run = 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    int n;
    n = 0;
    run = 1'b1;
    repeat (3) @(posedge link_clk);
    @(negedge link_clk);
    link_rd      = 1'b1;
    link_rd_addr = a;
    @(negedge link_clk);
    link_rd      = 1'b0;
    link_rd_addr = ~a;
    // Lost answer comes back as unknown data
    while (link_rd_valid !== 1'b1 && n < 40) begin
      @(negedge link_clk);
      n++;
    end
    d = (n < 40) ? link_rd_data : 8'hxx;
    repeat (2) @(posedge link_clk);
    run = 1'b0;
  endtask
endmodule

// ### dv/tb_ddcrb_bank.sv
// Self-checking bench of the converter control bank
`timescale 1ns/100ps
`include "ddcrb_regs.svh"
module tb_ddcrb_bank import ddcrb_pkg::*;;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        regulator_ok = 1'b1;
  logic        link_clk;
  logic        link_wr;
  logic [4:0]  link_wr_addr;
  logic [7:0]  link_wr_data;
  logic        link_rd;
  logic [4:0]  link_rd_addr;
  logic [7:0]  link_rd_data;
  logic        link_rd_valid;
  logic        link_bit_order;
  logic        link_long_address;
  logic        link_soft_reset;
  ddcrb_ctrl_t ctrl;
  int          err_count = 0;
  int          check_count = 0;
  int          cycles = 0;
  always #10 clk = ~clk;
  ddcrb_bank i_ddcrb_bank (.clk(clk), .rst_n(rst_n), .link_clk(link_clk), .link_wr(link_wr),
    .link_wr_addr(link_wr_addr), .link_wr_data(link_wr_data), .link_rd(link_rd), .link_rd_addr(link_rd_addr),
    .link_rd_data(link_rd_data), .link_rd_valid(link_rd_valid), .link_bit_order(link_bit_order),
    .link_long_address(link_long_address), .link_soft_reset(link_soft_reset), .regulator_ok(regulator_ok),
    .ctrl(ctrl));
  ddcrb_host_model i_ddcrb_host_model (.link_clk(link_clk), .link_wr(link_wr), .link_wr_addr(link_wr_addr),
    .link_wr_data(link_wr_data), .link_rd(link_rd), .link_rd_addr(link_rd_addr),
    .link_rd_data(link_rd_data), .link_rd_valid(link_rd_valid));
  // --------------------------------------------------------------------------
  // Shared helpers
  // --------------------------------------------------------------------------
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd_chk(input logic [4:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_ddcrb_host_model.rd(a, d);
    check($sformatf("register %h", a), d, exp);
  endtask
  function automatic logic [7:0] pw_vec();
    return {ctrl.regulator_disable, 1'b0, ctrl.power_down_all, ctrl.q_output_off, ctrl.i_output_off,
            ctrl.q_clock_gate, ctrl.i_clock_gate, ctrl.internal_ref_off};
  endfunction
  function automatic logic [7:0] sif_vec();
    return {2'b00, ctrl.twos_complement, ctrl.i_leads_pair, ctrl.i_on_rising_edge, ctrl.pad_in_en,
            ctrl.pad_out_en, ctrl.pad_out_double};
  endfunction
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_reset();
    rd_chk(5'h00, 8'h00);
    rd_chk(5'h01, 8'h40);
    rd_chk(5'h02, 8'h34);
    rd_chk(5'h11, 8'h34);
    rd_chk(5'h1f, `DDCRB_REVISION_CODE);
    check("sample ctrl", sif_vec(), 8'h1c);
    $display("test reset done");
  endtask
  task automatic t_masks();
    logic [23:0] tbl [11] = '{24'h03ff3f, 24'h04ffbf, 24'h0ea5a5, 24'h0fff0f, 24'h12ffdf, 24'h14ffcf,
                              24'h13ff00, 24'h1f005c, 24'h05ffbf, 24'h10ff3f, 24'h0a5a5a};
    foreach (tbl[i]) begin
      i_ddcrb_host_model.wr(tbl[i][20:16], tbl[i][15:8]);
      rd_chk(tbl[i][20:16], tbl[i][7:0]);
    end
    $display("test masks done");
  endtask
  task automatic t_power();
    for (int i = 0; i < 8; i++) begin
      i_ddcrb_host_model.wr(5'h01, 8'h01 << i);
      check("power ctrl", pw_vec(), (8'h01 << i) & 8'hbf);
      rd_chk(5'h01, ((8'h01 << i) & 8'hbf) | 8'h40);
    end
    i_ddcrb_host_model.wr(5'h01, 8'h00);
    @(negedge clk);
    regulator_ok = 1'b0;
    rd_chk(5'h01, 8'h00);
    @(negedge clk);
    regulator_ok = 1'b1;
    $display("test power done");
  endtask
  task automatic t_sample();
    logic [15:0] tbl [7] = '{16'h8020, 16'h3018, 16'h0e02, 16'h0606, 16'h0507, 16'h0d03, 16'h741c};
    foreach (tbl[i]) begin
      i_ddcrb_host_model.wr(5'h02, tbl[i][15:8]);
      check("sample ctrl", sif_vec(), tbl[i][7:0]);
      rd_chk(5'h02, tbl[i][15:8] & 8'hbf);
    end
    $display("test sample interface done");
  endtask
  task automatic t_soft();
    i_ddcrb_host_model.wr(5'h09, 8'h11);
    i_ddcrb_host_model.wr(5'h02, 8'h80);
    i_ddcrb_host_model.wr(5'h00, 8'h60);
    check("soft reset", {7'h00, ctrl.soft_reset}, 8'h01);
    check("link soft reset", {7'h00, link_soft_reset}, 8'h01);
    check("link bit order", {7'h00, link_bit_order}, 8'h01);
    check("bit order", {7'h00, ctrl.bit_order_select}, 8'h01);
    rd_chk(5'h03, 8'h00);
    rd_chk(5'h09, 8'h00);
    rd_chk(5'h02, 8'h34);
    i_ddcrb_host_model.wr(5'h09, 8'h22);
    rd_chk(5'h09, 8'h00);
    rd_chk(5'h00, 8'h60);
    rd_chk(5'h1f, `DDCRB_REVISION_CODE);
    i_ddcrb_host_model.wr(5'h00, 8'h10);
    check("link soft reset", {7'h00, link_soft_reset}, 8'h00);
    check("soft reset", {7'h00, ctrl.soft_reset}, 8'h00);
    check("address length", {7'h00, ctrl.long_address_mode}, 8'h01);
    check("link address length", {7'h00, link_long_address}, 8'h01);
    check("link bit order", {7'h00, link_bit_order}, 8'h00);
    i_ddcrb_host_model.wr(5'h09, 8'h33);
    rd_chk(5'h09, 8'h33);
    i_ddcrb_host_model.wr(5'h00, 8'h00);
    $display("test soft reset done");
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 6000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    t_reset();
    t_masks();
    t_power();
    t_sample();
    t_soft();
    stop_test();
  end
endmodule

// ### hdl/ddcrb_bank.sv
// Control register bank of the dual converter, fed byte-wise by the serial port framer
//
// Function
// - Reads return the last written value of every defined, non-status bit.
// - Serial config bit 6 picks bit order; 0 MSB first (reset), 1 LSB first.
// - Serial config bit 5 resets port and controllers; defaults reload except address 0.
// - Software reset holds while bit 5 is 1; host later writes 0 to release.
// - Serial config bit 4 picks 5-bit (0, reset) or 13-bit (1) address.
// - Power bit 7 disables the core regulator when 1; resets to 0.
// - Power bit 6 reads regulator state: 1 on, 0 off; not stored.
// - Power bit 5 powers down everything except serial port logic; resets 0.
// - Power bits 4 and 3 switch off Q and I output current; reset 0.
// - Power bits 2 and 1 gate Q and I conversion clocks; reset 0.
// - Power bit 0 powers down internal reference when 1; resets 0.
// - Sample control bit 7 selects unsigned (0, reset) or two's complement.
// - Sample control bit 5: 1 I first in pair (reset), 0 Q first.
// - Sample control bit 4: 1 I on rising data clock edge (reset), 0 Q.
// - Sample control bit 3: 1 forbids simultaneous pad input and output enable.
// - Sample control bit 2 enables the data clock pad input path.
// - The data clock input enable resets to 1.
// - Sample control bit 1 enables regular-strength data clock output; resets 0.
// - Sample control bit 0 adds a parallel driver for double current; resets 0.
// - Each byte takes effect in the core after its write toggle passes a two-flop clk synchroniser.
`timescale 1ns/100ps
module ddcrb_bank
  import ddcrb_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       link_clk,
  input  wire logic       link_wr,
  input  wire logic [4:0] link_wr_addr,
  input  wire logic [7:0] link_wr_data,
  input  wire logic       link_rd,
  input  wire logic [4:0] link_rd_addr,
  output logic      [7:0] link_rd_data,
  output logic            link_rd_valid,
  output logic            link_bit_order,
  output logic            link_long_address,
  output logic            link_soft_reset,
  input  wire logic       regulator_ok,
  output ddcrb_ctrl_t     ctrl
);

  // ----------------------------------------------------------------------------
  // Reset synchronisers
  // ----------------------------------------------------------------------------
  logic [1:0] core_rst_q;
  logic [1:0] link_rst_q;
  logic       core_rst_n;
  logic       link_rst_n;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      core_rst_q <= 2'h0;
    end else begin
      core_rst_q <= {core_rst_q[0], 1'b1};
    end
  end

  // Release on the serial clock so a stopped link clock holds the link side in reset
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      link_rst_q <= 2'h0;
    end else begin
      link_rst_q <= {link_rst_q[0], 1'b1};
    end
  end

  assign core_rst_n = core_rst_q[1];
  assign link_rst_n = link_rst_q[1];

  // ----------------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------------
  localparam ddcrb_link_t LINK_RST = '0;

  function automatic ddcrb_core_t core_rst_val();
    ddcrb_core_t c;
    c                             = '0;
    c.regs                        = ddcrb_regs_rst();
    c.ctrl.i_leads_pair           = 1'b1;
    c.ctrl.i_on_rising_edge       = 1'b1;
    c.ctrl.pad_in_en              = 1'b1;
    return c;
  endfunction

  localparam ddcrb_core_t CORE_RST = core_rst_val();

  ddcrb_link_t l;
  ddcrb_link_t next_l;
  ddcrb_core_t s;
  ddcrb_core_t next_s;

  // ----------------------------------------------------------------------------
  // Link side
  // ----------------------------------------------------------------------------
  always_comb begin
    next_l          = l;
    next_l.rd_valid = 1'b0;
    // Byte complete: park it and signal the core by a toggle
    if (link_wr) begin
      next_l.wr_hold.addr = link_wr_addr;
      next_l.wr_hold.data = link_wr_data;
      next_l.wr_tgl       = ~l.wr_tgl;
    end
    if (link_rd) begin
      next_l.rd_addr = link_rd_addr;
      next_l.rd_tgl  = ~l.rd_tgl;
    end
    next_l.ack_sync = {l.ack_sync[1:0], s.ack_tgl};
    // Core data stays still from its toggle until the next request
    if (l.ack_sync[2] ^ l.ack_sync[1]) begin
      next_l.rd_data  = s.rd_hold;
      next_l.rd_valid = 1'b1;
    end
    next_l.cfg_meta = {s.regs[`DDCRB_SERIAL_PORT_CONFIG][`DDCRB_BIT_ORDER_SELECT],
                       s.regs[`DDCRB_SERIAL_PORT_CONFIG][`DDCRB_LONG_ADDRESS_MODE],
                       s.regs[`DDCRB_SERIAL_PORT_CONFIG][`DDCRB_SOFT_RESET]};
    next_l.cfg_sync = l.cfg_meta;
  end

  always_ff @(posedge link_clk or negedge link_rst_n) begin
    if (!link_rst_n) begin
      l <= LINK_RST;
    end else begin
      l <= next_l;
    end
  end

  assign link_rd_data      = l.rd_data;
  assign link_rd_valid     = l.rd_valid;
  assign link_bit_order    = l.cfg_sync[2];
  assign link_long_address = l.cfg_sync[1];
  assign link_soft_reset   = l.cfg_sync[0];

  // ----------------------------------------------------------------------------
  // Core side
  // ----------------------------------------------------------------------------
  function automatic logic [7:0] read_val(input ddcrb_regs_t r, input logic [4:0] a, input logic ok);
    logic [7:0] v;
    v = r[a] & ddcrb_mask(a);
    if (a == `DDCRB_POWER_CONTROL) begin
      v[`DDCRB_REGULATOR_ON_FLAG] = ok;
    end
    if (a == `DDCRB_REVISION_ID) begin
      v = `DDCRB_REVISION_CODE;
    end
    return v;
  endfunction

  always_comb begin
    logic [4:0] wa;
    logic [7:0] wm;
    logic [7:0] pw;
    logic [7:0] si;
    wa     = l.wr_hold.addr;
    wm     = ddcrb_mask(wa);
    pw     = '0;
    si     = '0;
    next_s = s;
    next_s.wr_sync     = {s.wr_sync[1:0], l.wr_tgl};
    next_s.rd_sync     = {s.rd_sync[1:0], l.rd_tgl};
    next_s.reg_ok_sync = {s.reg_ok_sync[0], regulator_ok};
    // Holding register is stable once its toggle has passed two flops
    if (s.wr_sync[2] ^ s.wr_sync[1]) begin
      next_s.regs[wa] = (s.regs[wa] & ~wm) | (l.wr_hold.data & wm);
    end
    // Address 0 keeps its value, everything else is pinned to defaults
    if (next_s.regs[`DDCRB_SERIAL_PORT_CONFIG][`DDCRB_SOFT_RESET]) begin
      for (int i = 1; i < 32; i++) begin
        next_s.regs[i] = ddcrb_reset_val(5'(i));
      end
    end
    if (s.rd_sync[2] ^ s.rd_sync[1]) begin
      next_s.rd_hold = read_val(next_s.regs, l.rd_addr, s.reg_ok_sync[1]);
      next_s.ack_tgl = ~s.ack_tgl;
    end
    pw = next_s.regs[`DDCRB_POWER_CONTROL];
    si = next_s.regs[`DDCRB_SAMPLE_INTERFACE_CONTROL];
    next_s.ctrl.bit_order_select  = next_s.regs[`DDCRB_SERIAL_PORT_CONFIG][`DDCRB_BIT_ORDER_SELECT];
    next_s.ctrl.long_address_mode = next_s.regs[`DDCRB_SERIAL_PORT_CONFIG][`DDCRB_LONG_ADDRESS_MODE];
    next_s.ctrl.soft_reset        = next_s.regs[`DDCRB_SERIAL_PORT_CONFIG][`DDCRB_SOFT_RESET];
    next_s.ctrl.regulator_disable = pw[`DDCRB_REGULATOR_DISABLE];
    next_s.ctrl.power_down_all    = pw[`DDCRB_POWER_DOWN_ALL];
    next_s.ctrl.q_output_off      = pw[`DDCRB_Q_OUTPUT_OFF];
    next_s.ctrl.i_output_off      = pw[`DDCRB_I_OUTPUT_OFF];
    next_s.ctrl.q_clock_gate      = pw[`DDCRB_Q_CLOCK_GATE];
    next_s.ctrl.i_clock_gate      = pw[`DDCRB_I_CLOCK_GATE];
    next_s.ctrl.internal_ref_off  = pw[`DDCRB_INTERNAL_REF_OFF];
    next_s.ctrl.twos_complement   = si[`DDCRB_TWOS_COMPLEMENT];
    next_s.ctrl.i_leads_pair      = si[`DDCRB_I_LEADS_PAIR];
    next_s.ctrl.i_on_rising_edge  = si[`DDCRB_I_ON_RISING_EDGE];
    next_s.ctrl.pad_out_en        = si[`DDCRB_SAMPLE_CLOCK_OUT_SINGLE]
                                  | si[`DDCRB_SAMPLE_CLOCK_OUT_DOUBLE];
    next_s.ctrl.pad_out_double    = si[`DDCRB_SAMPLE_CLOCK_OUT_DOUBLE];
    // Output wins over input when both are asked for and bidirection is blocked
    next_s.ctrl.pad_in_en         = si[`DDCRB_SAMPLE_CLOCK_IN_ENABLE]
                                  & ~(si[`DDCRB_BLOCK_PAD_BIDIRECTION]
                                      & next_s.ctrl.pad_out_en);
  end

  always_ff @(posedge clk or negedge core_rst_n) begin
    if (!core_rst_n) begin
      s <= CORE_RST;
    end else begin
      s <= next_s;
    end
  end

  assign ctrl = s.ctrl;

endmodule

// ### include/ddcrb_pkg.sv
// Types and register helpers of the converter control bank
package ddcrb_pkg;
`include "ddcrb_regs.svh"

  typedef logic [31:0][7:0] ddcrb_regs_t;

  typedef struct packed {
    logic [4:0] addr;
    logic [7:0] data;
  } ddcrb_req_t;

  typedef struct packed {
    logic bit_order_select;
    logic long_address_mode;
    logic soft_reset;
    logic regulator_disable;
    logic power_down_all;
    logic q_output_off;
    logic i_output_off;
    logic q_clock_gate;
    logic i_clock_gate;
    logic internal_ref_off;
    logic twos_complement;
    logic i_leads_pair;
    logic i_on_rising_edge;
    logic pad_in_en;
    logic pad_out_en;
    logic pad_out_double;
  } ddcrb_ctrl_t;

  // Link-side state, clocked by the serial clock
  typedef struct packed {
    ddcrb_req_t wr_hold;
    logic       wr_tgl;
    logic [4:0] rd_addr;
    logic       rd_tgl;
    logic [2:0] ack_sync;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic [2:0] cfg_meta;
    logic [2:0] cfg_sync;
  } ddcrb_link_t;

  // Core-side state, clocked by clk
  typedef struct packed {
    ddcrb_regs_t regs;
    logic [2:0]  wr_sync;
    logic [2:0]  rd_sync;
    logic [7:0]  rd_hold;
    logic        ack_tgl;
    logic [1:0]  reg_ok_sync;
    ddcrb_ctrl_t ctrl;
  } ddcrb_core_t;

  function automatic logic [7:0] ddcrb_mask(input logic [4:0] a);
    case (a)
      `DDCRB_SERIAL_PORT_CONFIG:       ddcrb_mask = `DDCRB_MASK_SERIAL;
      `DDCRB_POWER_CONTROL:            ddcrb_mask = `DDCRB_MASK_POWER;
      `DDCRB_SAMPLE_INTERFACE_CONTROL: ddcrb_mask = `DDCRB_MASK_SAMPLE_IF;
      `DDCRB_I_FINE_GAIN,
      `DDCRB_Q_FINE_GAIN,
      `DDCRB_REFERENCE_RESISTOR,
      `DDCRB_CAL_MEMORY_POINTER,
      `DDCRB_CAL_MEMORY_WORD:          ddcrb_mask = `DDCRB_MASK_LOW6;
      `DDCRB_I_SCALE_RESISTOR,
      `DDCRB_I_COMMON_MODE_RESISTOR,
      `DDCRB_Q_SCALE_RESISTOR,
      `DDCRB_Q_COMMON_MODE_RESISTOR:   ddcrb_mask = `DDCRB_MASK_EN_LOW6;
      `DDCRB_Q_AUX_VALUE_LOW,
      `DDCRB_Q_AUX_CONTROL,
      `DDCRB_I_AUX_VALUE_LOW,
      `DDCRB_I_AUX_CONTROL,
      `DDCRB_CALIBRATION_CONTROL:      ddcrb_mask = `DDCRB_MASK_FULL;
      `DDCRB_CALIBRATION_STATUS:       ddcrb_mask = `DDCRB_MASK_CAL_STATUS;
      `DDCRB_CAL_MEMORY_ACCESS:        ddcrb_mask = `DDCRB_MASK_CAL_ACCESS;
      `DDCRB_RETIMER_CLOCK_MODE:       ddcrb_mask = `DDCRB_MASK_CLOCK_MODE;
      default:                         ddcrb_mask = `DDCRB_MASK_NONE;
    endcase
  endfunction

  function automatic logic [7:0] ddcrb_reset_val(input logic [4:0] a);
    case (a)
      `DDCRB_SAMPLE_INTERFACE_CONTROL: ddcrb_reset_val = `DDCRB_RST_SAMPLE_INTERFACE;
      `DDCRB_CAL_MEMORY_WORD:          ddcrb_reset_val = `DDCRB_RST_CAL_MEMORY_WORD;
      default:                         ddcrb_reset_val = `DDCRB_RST_ZERO;
    endcase
  endfunction

  function automatic ddcrb_regs_t ddcrb_regs_rst();
    ddcrb_regs_t r;
    for (int i = 0; i < 32; i++) begin
      r[i] = ddcrb_reset_val(5'(i));
    end
    return r;
  endfunction

endpackage

// ### include/ddcrb_regs.svh
// Register offsets, field positions, reset values and write masks of the converter control bank
`ifndef DDCRB_REGS_SVH
`define DDCRB_REGS_SVH

// ----------------------------------------------------------------------------
// Offsets
// ----------------------------------------------------------------------------
`define DDCRB_SERIAL_PORT_CONFIG       5'h00
`define DDCRB_POWER_CONTROL            5'h01
`define DDCRB_SAMPLE_INTERFACE_CONTROL 5'h02
`define DDCRB_I_FINE_GAIN              5'h03
`define DDCRB_I_SCALE_RESISTOR         5'h04
`define DDCRB_I_COMMON_MODE_RESISTOR   5'h05
`define DDCRB_Q_FINE_GAIN              5'h06
`define DDCRB_Q_SCALE_RESISTOR         5'h07
`define DDCRB_Q_COMMON_MODE_RESISTOR   5'h08
`define DDCRB_Q_AUX_VALUE_LOW          5'h09
`define DDCRB_Q_AUX_CONTROL            5'h0a
`define DDCRB_I_AUX_VALUE_LOW          5'h0b
`define DDCRB_I_AUX_CONTROL            5'h0c
`define DDCRB_REFERENCE_RESISTOR       5'h0d
`define DDCRB_CALIBRATION_CONTROL      5'h0e
`define DDCRB_CALIBRATION_STATUS       5'h0f
`define DDCRB_CAL_MEMORY_POINTER       5'h10
`define DDCRB_CAL_MEMORY_WORD          5'h11
`define DDCRB_CAL_MEMORY_ACCESS        5'h12
`define DDCRB_RETIMER_CLOCK_MODE       5'h14
`define DDCRB_REVISION_ID              5'h1f

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define DDCRB_BIT_ORDER_SELECT         6
`define DDCRB_SOFT_RESET               5
`define DDCRB_LONG_ADDRESS_MODE        4
`define DDCRB_REGULATOR_DISABLE        7
`define DDCRB_REGULATOR_ON_FLAG        6
`define DDCRB_POWER_DOWN_ALL           5
`define DDCRB_Q_OUTPUT_OFF             4
`define DDCRB_I_OUTPUT_OFF             3
`define DDCRB_Q_CLOCK_GATE             2
`define DDCRB_I_CLOCK_GATE             1
`define DDCRB_INTERNAL_REF_OFF         0
`define DDCRB_TWOS_COMPLEMENT          7
`define DDCRB_I_LEADS_PAIR             5
`define DDCRB_I_ON_RISING_EDGE         4
`define DDCRB_BLOCK_PAD_BIDIRECTION    3
`define DDCRB_SAMPLE_CLOCK_IN_ENABLE   2
`define DDCRB_SAMPLE_CLOCK_OUT_SINGLE  1
`define DDCRB_SAMPLE_CLOCK_OUT_DOUBLE  0

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define DDCRB_RST_ZERO                 8'h00
`define DDCRB_RST_SAMPLE_INTERFACE     8'h34
`define DDCRB_RST_CAL_MEMORY_WORD      8'h34
// Arbitrary revision code
`define DDCRB_REVISION_CODE            8'h5c

// ----------------------------------------------------------------------------
// Writable-bit masks
// ----------------------------------------------------------------------------
`define DDCRB_MASK_SERIAL              8'h70
`define DDCRB_MASK_POWER               8'hbf
`define DDCRB_MASK_SAMPLE_IF           8'hbf
`define DDCRB_MASK_LOW6                8'h3f
`define DDCRB_MASK_EN_LOW6             8'hbf
`define DDCRB_MASK_FULL                8'hff
`define DDCRB_MASK_CAL_STATUS          8'h0f
`define DDCRB_MASK_CAL_ACCESS          8'hdf
`define DDCRB_MASK_CLOCK_MODE          8'hcf
`define DDCRB_MASK_NONE                8'h00

`endif
